//--- src/pps_edge_detect.sv
// Rising-edge detector for the new set-point bit, sampled once per process-data cycle.
// Assumes the strobe marks a freshly received command word.
`timescale 1ns/1ps
module pps_edge_detect (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Sample
   input wire logic sampleStb,
   input wire logic level,
   input wire logic forceLow,
   // Result
   output logic rise
);
   import pps_pkg::*;
   typedef struct packed {
      logic prev;
   } pps_edge_st_t;
   pps_edge_st_t st_r, st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (forceLow) begin
         st_nxt.prev = 1'b0;
      end else if (sampleStb) begin
         st_nxt.prev = level;
      end
   end

   assign rise = sampleStb && level && !st_r.prev;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule

//--- src/pps_pkg.sv
// Constants, field layouts and state codes for the profile-position set-point controller.
// Assumes one core clock and synchronous process-data strobes from the fieldbus side.
package pps_pkg;
   localparam logic [15:0] CMD_WORD_INDEX = 16'h6040;
   localparam logic [15:0] OPT_WORD_INDEX = 16'h60F2;
   localparam logic [15:0] CMD_RESET = 16'h0000;
   localparam logic [15:0] OPT_RESET = 16'h0000;
   localparam int CMD_SWITCH_ON = 0;
   localparam int CMD_POWER_ON_VOLTAGE = 1;
   localparam int CMD_QUICK_HALT = 2;
   localparam int CMD_RUN_ENABLE = 3;
   localparam int CMD_NEW_SETPOINT = 4;
   localparam int CMD_CHANGE_NOW = 5;
   localparam int CMD_RELATIVE = 6;
   localparam int CMD_CLEAR_FAULT_FLAG = 7;
   localparam int CMD_HALT = 8;
   localparam int CMD_CHANGE_ON_SETPOINT = 9;
   localparam logic [15:0] CMD_IMPL_MASK = 16'h03FF;
   localparam logic [15:0] OPT_IMPL_MASK = 16'h803F;
   localparam int OPT_REL_LSB = 0;
   localparam int OPT_CIO_LSB = 2;
   localparam int OPT_RRO_LSB = 4;
   localparam int OPT_VENDOR_BIT = 15;
   localparam logic [1:0] REL_LAST_TARGET = 2'h0;
   localparam logic [1:0] REL_DEMAND = 2'h1;
   localparam logic [1:0] REL_ACTUAL = 2'h2;
   localparam logic [1:0] RRO_DEVICE_CLEARS = 2'h1;

   typedef enum logic [1:0] {
      PPS_IDLE = 2'b00,
      PPS_RUN = 2'b01,
      PPS_HALTING = 2'b10
   } pps_state_t;

   typedef struct packed {
      logic signed [31:0] target;
      logic [31:0] velocity;
      logic relative;
      logic [1:0] relOpt;
   } pps_task_t;
endpackage

//--- src/pps_setpoint_ctrl.sv
// Command word decoder and set-point manager for profile positioning mode.
// Assumes the fieldbus side writes both words with a one-cycle strobe per cycle,
// and that limit, prohibition and inhibit detection arrive as levels.
`timescale 1ns/1ps
module pps_setpoint_ctrl (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Process data writes
   input wire logic cmdWrStb,
   input wire logic [15:0] cmdWrData,
   input wire logic optWrStb,
   input wire logic [15:0] optWrData,
   input wire logic optNvLoad,
   input wire logic [15:0] optNvValue,
   // Task parameters
   input wire logic profilePositioning,
   input wire logic signed [31:0] targetIn,
   input wire logic [31:0] profileVelocity,
   input wire logic signed [31:0] demandPos,
   input wire logic signed [31:0] actualPos,
   // Motion and protection status
   input wire logic moveDone,
   input wire logic haltStopped,
   input wire logic swLimitPos,
   input wire logic swLimitNeg,
   input wire logic prohibitPos,
   input wire logic prohibitNeg,
   input wire logic runInhibit,
   // Register read-back
   output logic [15:0] cmdWord,
   output logic [15:0] optWord,
   // Decoded command bits
   output logic switchOn,
   output logic powerOnVoltage,
   output logic quickHaltN,
   output logic runEnable,
   output logic clearFaultFlag,
   output logic haltReq,
   // Set-point results
   output logic startPulse,
   output logic signed [31:0] runTarget,
   output logic [31:0] runVelocity,
   output logic setpointAck,
   output logic discardPulse,
   output logic [1:0] taskState
);
   import pps_pkg::*;

   typedef struct packed {
      logic [15:0] cmd;
      logic [15:0] opt;
      logic signed [31:0] lastTarget;
      logic hasLastTarget;
      logic decel;
      logic buffOpposite;
      logic runDirNeg;
      logic ack;
      logic discard;
      logic start;
      logic signed [31:0] runTgt;
      logic [31:0] runVel;
      logic [5:0] outBits;
      pps_state_t state;
   } pps_ctrl_st_t;
   pps_ctrl_st_t st_r, st_nxt;

   pps_task_if tif ();
   logic rise;
   logic slotStart;
   pps_task_t slotTask;
   logic discardAll;
   logic slotFlush;
   logic autoClear;
   logic signed [31:0] refPos;
   logic signed [31:0] absTarget;
   logic signed [31:0] basePos;
   logic dirNeg;
   logic blocked;
   logic accept;

   // The device-side clear only drops the stored set-point bit; the edge detector still samples the master's bit 4 unchanged.
   assign autoClear = st_r.ack && (st_r.opt[OPT_RRO_LSB +: 2] == RRO_DEVICE_CLEARS);

   pps_edge_detect u_edge (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .sampleStb(cmdWrStb && profilePositioning),
      .level(cmdWrData[CMD_NEW_SETPOINT]),
      .forceLow(1'b0),
      .rise(rise)
   );

   // Reference selection for relative targets
   always_comb begin
      case (st_r.opt[OPT_REL_LSB +: 2])
         REL_LAST_TARGET: refPos = st_r.hasLastTarget ? st_r.lastTarget : 32'sh0;
         REL_DEMAND: refPos = demandPos;
         REL_ACTUAL: refPos = actualPos;
         default: refPos = st_r.lastTarget;
      endcase
   end

   assign absTarget = cmdWrData[CMD_RELATIVE] ? 32'(refPos + targetIn) : targetIn;
   assign basePos = st_r.state == PPS_IDLE ? actualPos : st_r.runTgt;
   assign dirNeg = absTarget < basePos;

   always_comb begin
      blocked = 1'b0;
      if (profileVelocity == 32'h0) begin
         blocked = 1'b1;
      end else if ((swLimitPos && !dirNeg) || (swLimitNeg && dirNeg)) begin
         blocked = 1'b1;
      end else if ((prohibitPos && !dirNeg) || (prohibitNeg && dirNeg)) begin
         blocked = 1'b1;
      end
   end

   assign accept = rise && !blocked;
   assign discardAll = runInhibit && ((st_r.state == PPS_HALTING) || st_r.buffOpposite);
   // A halt stop ends the running task, so idle really means no task in the slot
   assign slotFlush = discardAll || ((st_r.state == PPS_HALTING) && haltStopped);

   assign tif.load = accept;
   // Bit 9 never enters the decision; bits 3-2 only support code zero.
   assign tif.immediate = cmdWrData[CMD_CHANGE_NOW];
   assign tif.task_d = '{target: absTarget, velocity: profileVelocity,
      relative: cmdWrData[CMD_RELATIVE], relOpt: st_r.opt[OPT_REL_LSB +: 2]};

   pps_task_slot u_slot (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .tif(tif),
      .moveDone(moveDone),
      .discardAll(slotFlush),
      .startStb(slotStart),
      .runTask(slotTask)
   );

   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      st_nxt.discard = 1'b0;
      st_nxt.start = slotStart;
      if (cmdWrStb) begin
         st_nxt.cmd = cmdWrData & CMD_IMPL_MASK;
      end
      if (optNvLoad) begin
         st_nxt.opt = optNvValue & OPT_IMPL_MASK;
      end else if (optWrStb) begin
         st_nxt.opt = optWrData & OPT_IMPL_MASK;
      end
      if (autoClear) begin
         st_nxt.cmd[CMD_NEW_SETPOINT] = 1'b0;
      end
      if (accept) begin
         st_nxt.ack = 1'b1;
         st_nxt.lastTarget = absTarget;
         st_nxt.hasLastTarget = 1'b1;
         if (tif.busy && !cmdWrData[CMD_CHANGE_NOW]) begin
            st_nxt.buffOpposite = dirNeg != st_r.runDirNeg;
         end else begin
            st_nxt.runDirNeg = dirNeg;
            st_nxt.buffOpposite = 1'b0;
         end
      end
      if (rise && blocked) begin
         st_nxt.discard = 1'b1;
      end
      if (slotStart) begin
         st_nxt.runTgt = slotTask.target;
         st_nxt.runVel = slotTask.velocity;
      end
      if (!profilePositioning) begin
         st_nxt.hasLastTarget = 1'b0;
      end
      case (st_r.state)
         PPS_IDLE: begin
            if (slotStart) begin
               st_nxt.state = PPS_RUN;
            end
         end
         PPS_RUN: begin
            if (st_r.cmd[CMD_HALT]) begin
               st_nxt.state = PPS_HALTING;
            end else if (!tif.busy && !slotStart) begin
               st_nxt.state = PPS_IDLE;
            end
         end
         PPS_HALTING: begin
            if (haltStopped) begin
               // Halt stop wipes the immediate, bit 9 and option settings of that task.
               st_nxt.cmd[CMD_CHANGE_NOW] = 1'b0;
               st_nxt.cmd[CMD_CHANGE_ON_SETPOINT] = 1'b0;
               st_nxt.opt = OPT_RESET;
               st_nxt.buffOpposite = 1'b0;
               st_nxt.state = PPS_IDLE;
            end
         end
         default: st_nxt.state = PPS_IDLE;
      endcase
      if (discardAll) begin
         st_nxt.discard = 1'b1;
         st_nxt.buffOpposite = 1'b0;
         st_nxt.state = PPS_IDLE;
      end
      st_nxt.outBits = {st_nxt.cmd[CMD_HALT], st_nxt.cmd[CMD_CLEAR_FAULT_FLAG],
         st_nxt.cmd[CMD_RUN_ENABLE], st_nxt.cmd[CMD_QUICK_HALT],
         st_nxt.cmd[CMD_POWER_ON_VOLTAGE], st_nxt.cmd[CMD_SWITCH_ON]};
   end

   assign cmdWord = st_r.cmd;
   assign optWord = st_r.opt;
   assign {haltReq, clearFaultFlag, runEnable, quickHaltN, powerOnVoltage, switchOn} =
      st_r.outBits;
   assign startPulse = st_r.start;
   assign runTarget = st_r.runTgt;
   assign runVelocity = st_r.runVel;
   assign setpointAck = st_r.ack;
   assign discardPulse = st_r.discard;
   assign taskState = st_r.state;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
         st_r.cmd <= CMD_RESET;
         st_r.opt <= OPT_RESET;
         st_r.state <= PPS_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule

//--- src/pps_task_if.sv
// Carries a resolved positioning task from the decoder to the task slot logic.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface pps_task_if;
   import pps_pkg::*;
   logic load;
   logic immediate;
   pps_task_t task_d;
   logic busy;
   logic pending;
   modport src (output load, output immediate, output task_d, input busy, input pending);
   modport dst (input load, input immediate, input task_d, output busy, output pending);
endinterface

//--- src/pps_task_slot.sv
// Running and buffered task slots with queued versus immediate hand-over.
// Assumes motion done is a pulse from the trajectory generator.
`timescale 1ns/1ps
module pps_task_slot (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // From decoder
   pps_task_if.dst tif,
   // Motion side
   input wire logic moveDone,
   input wire logic discardAll,
   // Results
   output logic startStb,
   output pps_pkg::pps_task_t runTask
);
   import pps_pkg::*;
   typedef struct packed {
      pps_task_t run;
      pps_task_t buffered;
      logic running;
      logic buffValid;
      logic start;
   } pps_slot_st_t;
   pps_slot_st_t st_r, st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.start = 1'b0;
      if (discardAll) begin
         st_nxt.running = 1'b0;
         st_nxt.buffValid = 1'b0;
      end else begin
         if (moveDone && st_r.running) begin
            st_nxt.running = st_r.buffValid;
            if (st_r.buffValid) begin
               st_nxt.run = st_r.buffered;
               st_nxt.buffValid = 1'b0;
               st_nxt.start = 1'b1;
            end
         end
         if (tif.load) begin
            if (tif.immediate || !st_nxt.running) begin
               st_nxt.run = tif.task_d;
               st_nxt.running = 1'b1;
               st_nxt.buffValid = 1'b0;
               st_nxt.start = 1'b1;
            end else begin
               st_nxt.buffered = tif.task_d;
               st_nxt.buffValid = 1'b1;
            end
         end
      end
   end

   assign tif.busy = st_r.running;
   assign tif.pending = st_r.buffValid;
   assign startStb = st_r.start;
   assign runTask = st_r.run;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule

//--- verification/pps_master_model.sv
// Fieldbus master model framing cyclic command and option words.
// Assumes bench requests are raised just after a rising edge.
`timescale 1ns/1ps
module pps_master_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Bench requests
   input wire logic cmdReq,
   input wire logic [15:0] cmdVal,
   input wire logic optReq,
   input wire logic [15:0] optVal,
   // Process data
   output logic cmdWrStb,
   output logic [15:0] cmdWrData,
   output logic optWrStb,
   output logic [15:0] optWrData
);
   // Stale words are inverted so a held value is never mistaken for new data
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmdWrStb <= 1'b0;
         optWrStb <= 1'b0;
         cmdWrData <= 16'h0000;
         optWrData <= 16'h0000;
      end else begin
         cmdWrStb <= cmdReq;
         optWrStb <= optReq;
         cmdWrData <= cmdReq ? cmdVal : ~cmdWrData;
         optWrData <= optReq ? (optVal & 16'hFFF3) : ~optWrData;
      end
   end
endmodule

//--- verification/pps_setpoint_ctrl_properties.sv
// Checker for the set-point controller, bound to its top module.
// Assumes one core clock and the async active-low reset.
`timescale 1ns/1ps
module pps_setpoint_ctrl_properties (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Inputs
   input wire logic cmdWrStb,
   input wire logic [15:0] cmdWrData,
   input wire logic optWrStb,
   input wire logic [15:0] optWrData,
   input wire logic optNvLoad,
   input wire logic [15:0] optNvValue,
   input wire logic profilePositioning,
   input wire logic [31:0] profileVelocity,
   input wire logic haltStopped,
   input wire logic runInhibit,
   // Outputs
   input wire logic [15:0] cmdWord,
   input wire logic [15:0] optWord,
   input wire logic switchOn,
   input wire logic powerOnVoltage,
   input wire logic quickHaltN,
   input wire logic runEnable,
   input wire logic clearFaultFlag,
   input wire logic haltReq,
   input wire logic startPulse,
   input wire logic setpointAck,
   input wire logic discardPulse,
   input wire logic [1:0] taskState
);
   logic prevBit4_r;
   logic trig;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) prevBit4_r <= 1'b0;
      else if (cmdWrStb) prevBit4_r <= cmdWrData[4];
   end
   assign trig = cmdWrStb && profilePositioning && cmdWrData[4] && !prevBit4_r;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_ack_cause: assert property (setpointAck |-> $past(trig))
      else $error("ack without a set-point edge");
   a_ack_velocity: assert property (setpointAck |-> $past(profileVelocity) != 32'h0)
      else $error("ack with zero velocity");
   a_zero_discard: assert property (trig && profileVelocity == 32'h0 |=> discardPulse && !setpointAck)
      else $error("zero velocity trigger kept");
   a_idle_start: assert property (setpointAck && taskState == 2'h0 |=> startPulse)
      else $error("idle trigger did not start");
   a_now_start: assert property (setpointAck && cmdWord[5] |=> startPulse)
      else $error("immediate trigger did not start");
   a_start_state: assert property (startPulse |-> taskState == 2'h1)
      else $error("start without run state");
   a_cmd_store: assert property (cmdWrStb && !haltStopped |=> cmdWord == ($past(cmdWrData) & 16'h03FF))
      else $error("command word not stored");
   a_bit_decode: assert property ({haltReq, clearFaultFlag, runEnable, quickHaltN, powerOnVoltage,
      switchOn} == {cmdWord[8:7], cmdWord[3:0]})
      else $error("decoded bits differ from word");
   a_opt_store: assert property (optWrStb && !optNvLoad && !haltStopped |=>
      optWord == ($past(optWrData) & 16'h803F))
      else $error("option word not stored");
   a_nv_restore: assert property (optNvLoad && !haltStopped |=> optWord == ($past(optNvValue) & 16'h803F))
      else $error("option restore failed");
   a_rro_clear: assert property (setpointAck && optWord[5:4] == 2'h1 |-> ##[1:2] !cmdWord[4])
      else $error("set-point bit not cleared");
   a_halt_clear: assert property (haltStopped && taskState == 2'h2 |-> ##[1:2]
      (optWord == 16'h0000 && !cmdWord[5] && !cmdWord[9]))
      else $error("halt stop left options set");
   a_inhibit_drop: assert property (runInhibit && taskState == 2'h2 |-> ##[1:2] taskState == 2'h0)
      else $error("inhibit during halt kept task");
   c_start: cover property (startPulse);
   c_discard: cover property (discardPulse);
   c_halting: cover property (taskState == 2'h2);
endmodule
bind pps_setpoint_ctrl pps_setpoint_ctrl_properties chk_u (.core_clk, .reset_n, .cmdWrStb,
   .cmdWrData, .optWrStb, .optWrData, .optNvLoad, .optNvValue, .profilePositioning,
   .profileVelocity, .haltStopped, .runInhibit, .cmdWord, .optWord, .switchOn, .powerOnVoltage,
   .quickHaltN, .runEnable, .clearFaultFlag, .haltReq, .startPulse, .setpointAck, .discardPulse,
   .taskState);

//--- verification/test_profile_position_setpoint_ctrl.sv
// Self-checking bench for the set-point controller.
// Assumes the master model frames every word the bench sends.
`timescale 1ns/1ps
module test_profile_position_setpoint_ctrl;
   import pps_pkg::*;
   logic core_clk = 1'b0, reset_n = 1'b0, cmdReq = 1'b0, optReq = 1'b0, optNvLoad = 1'b0;
   logic moveDone = 1'b0, haltStopped = 1'b0, swLimitPos = 1'b0, prohibitPos = 1'b0;
   logic runInhibit = 1'b0, swLimitNeg = 1'b0, prohibitNeg = 1'b0, profilePositioning = 1'b1;
   logic [15:0] cmdVal = 16'h0000, optVal = 16'h0000, optNvValue = 16'h0000;
   logic signed [31:0] targetIn = 0, demandPos = 0, actualPos = 0, lastT, expT;
   logic [31:0] profileVelocity = 100; // No acceleration inputs; only velocity varies
   logic cmdWrStb, optWrStb, switchOn, powerOnVoltage, quickHaltN, runEnable, clearFaultFlag;
   logic haltReq, startPulse, setpointAck, discardPulse;
   logic [15:0] cmdWrData, optWrData, cmdWord, optWord;
   logic signed [31:0] runTarget;
   logic [31:0] runVelocity;
   logic [1:0] taskState;
   int error_cnt = 0, checks_done = 0, nAck = 0, nStart = 0, nDisc = 0, i;
   always #2 core_clk = ~core_clk;
   pps_master_model master_u (.core_clk, .reset_n, .cmdReq, .cmdVal, .optReq, .optVal,
      .cmdWrStb, .cmdWrData, .optWrStb, .optWrData);
   pps_setpoint_ctrl dut_u (.core_clk, .reset_n, .cmdWrStb, .cmdWrData, .optWrStb, .optWrData,
      .optNvLoad, .optNvValue, .profilePositioning, .targetIn, .profileVelocity,
      .demandPos, .actualPos, .moveDone, .haltStopped, .swLimitPos, .swLimitNeg,
      .prohibitPos, .prohibitNeg, .runInhibit, .cmdWord, .optWord, .switchOn,
      .powerOnVoltage, .quickHaltN, .runEnable, .clearFaultFlag, .haltReq, .startPulse,
      .runTarget, .runVelocity, .setpointAck, .discardPulse, .taskState);
   // Pulses counted mid-cycle, clear of the edge at which tasks reset the counters
   always @(negedge core_clk) begin
      nAck += setpointAck;
      nStart += startPulse;
      nDisc += discardPulse;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task cnt(input int a, input int s, input int d);
      chk(nAck, a);
      chk(nStart, s);
      chk(nDisc, d);
   endtask
   task tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task wcmd(input logic [15:0] v);
      nAck = 0;
      nStart = 0;
      nDisc = 0;
      cmdReq <= 1'b1;
      cmdVal <= v;
      tick(1);
      cmdReq <= 1'b0;
      tick(6); // Start spacing scaled down to keep runs short
   endtask
   task inhibit;
      runInhibit <= 1'b1;
      tick(1);
      runInhibit <= 1'b0;
      tick(3);
   endtask
   task wopt(input logic [15:0] v);
      optReq <= 1'b1;
      optVal <= v;
      tick(1);
      optReq <= 1'b0;
      tick(3);
   endtask
   task done;
      nStart = 0;
      moveDone <= 1'b1;
      tick(1);
      moveDone <= 1'b0;
      tick(5);
   endtask
   task final_report;
      if (error_cnt == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #20000;
      error_cnt++;
      final_report();
   end
   initial begin
      tick(10);
      reset_n <= 1'b1;
      tick(2);
      chk(cmdWord, CMD_RESET);
      chk(optWord, OPT_RESET);
      targetIn <= 1000;
      wcmd(16'hFC9F);
      chk(cmdWord, 16'h009F);
      chk({haltReq, clearFaultFlag, runEnable, quickHaltN, powerOnVoltage, switchOn}, 6'h1F);
      cnt(1, 1, 0);
      chk(runTarget, 1000);
      chk(runVelocity, 100);
      // Bit 4 returned low before every new edge
      wcmd(16'h000F);
      targetIn <= 2000;
      wcmd(16'h001F);
      cnt(1, 0, 0);
      wcmd(16'h000F);
      done();
      chk(nStart, 1);
      chk(runTarget, 2000);
      targetIn <= 3000;
      wcmd(16'h003F);
      cnt(1, 1, 0);
      chk(runTarget, 3000);
      wcmd(16'h000F);
      targetIn <= 4000;
      wcmd(16'h021F);
      cnt(1, 0, 0);
      wcmd(16'h000F);
      done();
      chk(runTarget, 4000);
      lastT = 0;
      // Leaving the mode forgets the last target, so the reference is zero
      profilePositioning <= 1'b0;
      tick(1);
      profilePositioning <= 1'b1;
      demandPos <= 500;
      actualPos <= 700;
      targetIn <= 10;
      for (i = 0; i < 3; i++) begin
         wopt(16'(i));
         wcmd(16'h007F);
         expT = (i == 0) ? lastT + 10 : (i == 1) ? 510 : 710;
         chk(runTarget, expT);
         lastT = expT;
         wcmd(16'h000F);
      end
      wopt(16'hFFFF);
      chk(optWord, 16'h8033);
      optNvLoad <= 1'b1;
      optNvValue <= 16'h4012;
      tick(1);
      optNvLoad <= 1'b0;
      tick(2);
      chk(optWord, 16'h0012);
      targetIn <= 20;
      wcmd(16'h003F);
      chk(cmdWord, 16'h002F);
      chk(runTarget, 20);
      wcmd(16'h000F);
      // Zero velocity first, then a target on the limited or prohibited side of the running move
      for (i = 0; i < 5; i++) begin
         profileVelocity <= (i == 0) ? 0 : 100;
         targetIn <= (i < 3) ? 900 : -900;
         swLimitPos <= (i == 1);
         swLimitNeg <= (i == 3);
         prohibitPos <= (i == 2);
         prohibitNeg <= (i == 4);
         wcmd(16'h001F);
         cnt(0, 0, 1);
         wcmd(16'h000F);
      end
      swLimitPos <= 1'b0;
      swLimitNeg <= 1'b0;
      prohibitPos <= 1'b0;
      prohibitNeg <= 1'b0;
      profileVelocity <= 100;
      wopt(16'h0001);
      wcmd(16'h032F);
      chk(haltReq, 1'b1);
      chk(taskState, 2'h2);
      haltStopped <= 1'b1;
      tick(1);
      haltStopped <= 1'b0;
      tick(3);
      chk({cmdWord[9], cmdWord[5]}, 2'h0);
      chk(optWord, 16'h0000);
      wcmd(16'h000F);
      targetIn <= 50;
      wcmd(16'h001F);
      wcmd(16'h010F);
      chk(taskState, 2'h2);
      inhibit();
      chk(taskState, 2'h0);
      chk(nDisc, 1);
      // Queued move heads the other way from the running one
      targetIn <= 100;
      wcmd(16'h001F);
      wcmd(16'h000F);
      targetIn <= 2000;
      wcmd(16'h001F);
      chk(taskState, 2'h1);
      inhibit();
      chk(taskState, 2'h0);
      chk(nDisc, 1);
      final_report();
   end
endmodule
